// [psmux_top.sv]
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - mode select high makes configuration registers reachable over smbus.
// - mode select low refuses smbus access; shared pins set eq and de-emphasis.
// - mode select high turns the side a de-emphasis pin into smbus clock.
// - smbus data pin is sampled and only ever driven low.
// - smbus answers only the address set by four strap pins.
// - equalization pins of both sides count only while mode select is low.
// - in pin mode all four lanes of a side share one setting.
// - mode select high gives per-lane control; side b eq pins become upper address.
// - de-emphasis pins of both sides count only while mode select is low.
// - side b de-emphasis pins become lower address, side a pins data and clock.
// - float-capable pins decode low, high or undriven middle as three choices.
// - rate, eq and de-emphasis move to registers as soon as mode goes high.
// - registers return to defaults at reset and while mode select is low.
// - cable-absent input leaves register contents untouched.
// - other pins stay active unless their override bit is set in a register.
module psmux_top (
  input  wire logic                              clock,
  input  wire logic                              rst,
  input  wire logic                              link_clk,
  input  wire logic                              serial_mgmt_mode_select,
  input  wire psmux_pkg::psmux_tri_t [1:0]       side_a_equalize_level_pins,
  input  wire psmux_pkg::psmux_tri_t [1:0]       side_b_equalize_level_pins,
  input  wire psmux_pkg::psmux_tri_t [1:0]       side_a_deemph_level_pins,
  input  wire psmux_pkg::psmux_tri_t [1:0]       side_b_deemph_level_pins,
  input  wire psmux_pkg::psmux_tri_t             rate_pin,
  input  wire psmux_pkg::psmux_tri_t [1:0]       tx_idle_pins,
  input  wire logic [1:0]                        rx_detect_pins,
  input  wire logic                              cable_absent_input,
  output logic                                   sda_out,
  output logic                                   sda_oe,
  input  wire logic [psmux_pkg::REG_AW-1:0]      reg_addr,
  input  wire logic [7:0]                        reg_wdata,
  input  wire logic                              reg_we,
  input  wire logic                              reg_re,
  output logic [7:0]                             reg_rdata,
  output psmux_pkg::psmux_lane_t [psmux_pkg::LANES-1:0] lane_cfg,
  output logic [1:0]                             rate_sel,
  output logic [1:0]                             rx_detect_sel,
  output logic [3:0]                             tx_idle_sel,
  output logic                                   low_power,
  output logic                                   smb_mode
);
  // ==========================================================
  // synchronisers, system clock
  psmux_pkg::psmux_pins_t pins_raw, pins_m1, pins_q;
  logic [1:0]             mode_m;
  logic                   mode_s;
  logic [3:0]             straps_q;

  always_comb
  begin
    pins_raw.eqa    = side_a_equalize_level_pins;
    pins_raw.eqb    = side_b_equalize_level_pins;
    pins_raw.dema   = side_a_deemph_level_pins;
    pins_raw.demb   = side_b_deemph_level_pins;
    pins_raw.txidle = tx_idle_pins;
    pins_raw.rate   = rate_pin;
    pins_raw.rxdet  = rx_detect_pins;
    pins_raw.absent = cable_absent_input;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode_m  <= 2'h0;
      pins_m1 <= '0;
      pins_q  <= '0;
    end
    else
    begin
      mode_m  <= {mode_m[0], serial_mgmt_mode_select};
      pins_m1 <= pins_raw;
      pins_q  <= pins_m1;
    end
  end

  assign mode_s   = mode_m[1];
  assign smb_mode = mode_s;
  // upper address from side b eq pins, lower from side b de-emphasis pins
  assign straps_q = {pins_q.eqb[0].hi, pins_q.eqb[1].hi,
                     pins_q.demb[0].hi, pins_q.demb[1].hi};

  // ==========================================================
  // smbus side, link clock
  logic [1:0]            lrst_m, lmode_m;
  logic                  link_rst;
  logic [3:0]            slave_addr_straps;
  psmux_pkg::psmux_req_t req;
  logic                  req_tgl;
  logic [7:0]            rsp_data_q;
  logic                  rsp_tgl_q;

  always_ff @(posedge link_clk)
  begin
    lrst_m  <= {lrst_m[0], rst};
    lmode_m <= {lmode_m[0], mode_s};
  end

  assign link_rst = lrst_m[1] | ~lmode_m[1];
  assign sda_out  = 1'b0;
  assign slave_addr_straps = {side_b_equalize_level_pins[0].hi,
                              side_b_equalize_level_pins[1].hi,
                              side_b_deemph_level_pins[0].hi,
                              side_b_deemph_level_pins[1].hi};

  psmux_smb_slave u_slave (
    .link_clk  (link_clk),
    .link_rst  (link_rst),
    .scl_pin   (side_a_deemph_level_pins[1].hi),
    .sda_pin   (side_a_deemph_level_pins[0].hi),
    .addr_pin  (slave_addr_straps),
    .rsp_data  (rsp_data_q),
    .rsp_tgl   (rsp_tgl_q),
    .sda_oe    (sda_oe),
    .req_q     (req),
    .req_tgl_q (req_tgl)
  );

  // ==========================================================
  // smbus request crossing
  logic [1:0] req_m;
  logic       req_seen_q, req_new, swr;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      req_m      <= 2'h0;
      req_seen_q <= 1'b0;
    end
    else
    begin
      req_m      <= {req_m[0], req_tgl};
      req_seen_q <= req_m[1];
    end
  end

  assign req_new = (req_m[1] != req_seen_q) & mode_s;
  assign swr     = req_new & req.wr;

  // ==========================================================
  // register file
  psmux_pkg::psmux_lane_t [psmux_pkg::LANES-1:0] lane_q;
  logic [7:0]                                    ctrl_q, idle_q;

  function automatic logic [7:0] reg_next(input logic [7:0] cur,
                                          input logic [3:0] idx);
    reg_next = cur;
    if (swr && req.idx == {4'h0, idx})
      reg_next = req.data;
    if (reg_we && reg_addr == idx)
      reg_next = reg_wdata;
  endfunction

  function automatic logic [7:0] reg_rd(input logic [3:0] a);
    if (a < 4'(psmux_pkg::LANES))
      reg_rd = lane_q[a[2:0]];
    else if (a == psmux_pkg::REG_CTRL)
      reg_rd = ctrl_q;
    else if (a == psmux_pkg::REG_IDLE)
      reg_rd = idle_q;
    else if (a == psmux_pkg::REG_STAT)
      reg_rd = {2'h0, straps_q, pins_q.absent, mode_s};
    else
      reg_rd = 8'h00;
  endfunction

  always_ff @(posedge clock)
  begin
    if (rst || !mode_s)
    begin
      lane_q <= {psmux_pkg::LANES{psmux_pkg::LANE_RST}};
      ctrl_q <= psmux_pkg::CTRL_RST;
      idle_q <= psmux_pkg::IDLE_RST;
    end
    else
    begin
      // cable absent takes no part here, so contents hold
      for (int i = 0; i < psmux_pkg::LANES; i++)
        lane_q[i] <= reg_next(lane_q[i], 4'(i));
      ctrl_q <= reg_next(ctrl_q, psmux_pkg::REG_CTRL);
      idle_q <= reg_next(idle_q, psmux_pkg::REG_IDLE);
    end
  end

  // ==========================================================
  // read paths
  always_ff @(posedge clock)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_re ? reg_rd(reg_addr) : 8'h00;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rsp_data_q <= 8'h00;
      rsp_tgl_q  <= 1'b0;
    end
    else if (req_new && !req.wr)
    begin
      rsp_data_q <= (req.idx[7:4] == 4'h0) ? reg_rd(req.idx[3:0]) : 8'h00;
      rsp_tgl_q  <= ~rsp_tgl_q;
    end
  end

  // ==========================================================
  // lane settings
  logic [3:0] eq_a, eq_b, dem_a, dem_b;

  assign eq_a  = {psmux_pkg::tri_dec(pins_q.eqa[1]), psmux_pkg::tri_dec(pins_q.eqa[0])};
  assign eq_b  = {psmux_pkg::tri_dec(pins_q.eqb[1]), psmux_pkg::tri_dec(pins_q.eqb[0])};
  assign dem_a = {psmux_pkg::tri_dec(pins_q.dema[1]), psmux_pkg::tri_dec(pins_q.dema[0])};
  assign dem_b = {psmux_pkg::tri_dec(pins_q.demb[1]), psmux_pkg::tri_dec(pins_q.demb[0])};

  always_ff @(posedge clock)
  begin
    if (rst)
      lane_cfg <= '0;
    else
      for (int i = 0; i < psmux_pkg::LANES; i++)
        if (mode_s)
          lane_cfg[i] <= lane_q[i];
        else if (i < psmux_pkg::SIDE_LANES)
          lane_cfg[i] <= '{deemph: dem_a, eq: eq_a};
        else
          lane_cfg[i] <= '{deemph: dem_b, eq: eq_b};
  end

  // ==========================================================
  // rate, receiver detect, idle
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rate_sel      <= psmux_pkg::TRI_MID;
      rx_detect_sel <= 2'h0;
      tx_idle_sel   <= {psmux_pkg::TRI_MID, psmux_pkg::TRI_MID};
      low_power     <= 1'b0;
    end
    else
    begin
      rate_sel <= mode_s ? ctrl_q[psmux_pkg::CTRL_RATE+:2]
                         : psmux_pkg::tri_dec(pins_q.rate);
      if (mode_s && ctrl_q[psmux_pkg::CTRL_RXOVR])
        rx_detect_sel <= ctrl_q[psmux_pkg::CTRL_RXDET+:2];
      else
        rx_detect_sel <= pins_q.rxdet;
      if (mode_s && idle_q[psmux_pkg::IDLE_OVR])
        tx_idle_sel <= idle_q[3:0];
      else
        tx_idle_sel <= {psmux_pkg::tri_dec(pins_q.txidle[1]),
                        psmux_pkg::tri_dec(pins_q.txidle[0])};
      low_power <= pins_q.absent;
    end
  end

  // ==========================================================
  // checks
  regs_cleared_a: assert property (@(posedge clock) disable iff (rst)
    !mode_s |=> lane_q[0] == psmux_pkg::LANE_RST && ctrl_q == psmux_pkg::CTRL_RST)
    else $error("registers not back at defaults");
  pin_eq_a: assert property (@(posedge clock) disable iff (rst)
    !mode_s |=> lane_cfg[0].eq == $past(eq_a) && lane_cfg[4].eq == $past(eq_b))
    else $error("pin equalization not applied");
  lanes_shared_a: assert property (@(posedge clock) disable iff (rst)
    $past(!mode_s) |-> lane_cfg[0] == lane_cfg[3] && lane_cfg[4] == lane_cfg[7])
    else $error("lanes of one side differ in pin mode");
  lane_regs_a: assert property (@(posedge clock) disable iff (rst)
    mode_s |=> lane_cfg[5] == $past(lane_q[5]))
    else $error("lane not under register control");
  rate_reg_a: assert property (@(posedge clock) disable iff (rst)
    mode_s ##1 mode_s |-> rate_sel == $past(ctrl_q[1:0]))
    else $error("rate not under register control");
  absent_keep_a: assert property (@(posedge clock) disable iff (rst)
    mode_s && pins_q.absent && !reg_we && !swr ##1 mode_s |-> $stable(lane_q))
    else $error("registers changed with cable absent");
  rx_ovr_a: assert property (@(posedge clock) disable iff (rst)
    mode_s && ctrl_q[psmux_pkg::CTRL_RXOVR] |=> rx_detect_sel == $past(ctrl_q[4:3]))
    else $error("override bit ignored");
  smb_refused_a: assert property (@(posedge clock) disable iff (rst)
    !mode_s |=> $stable(rsp_tgl_q) && lane_q[1] == psmux_pkg::LANE_RST)
    else $error("smbus access in pin mode");
  mode_sync_a: assert property (@(posedge clock) disable iff (rst)
    $rose(mode_s) |-> $past(serial_mgmt_mode_select, 2))
    else $error("mode switched on unsynchronised level");
  sda_release_a: assert property (@(posedge link_clk) disable iff (lrst_m[1])
    !lmode_m[1] |=> !sda_oe)
    else $error("data pin driven outside smbus mode");

  mode_rise_c: cover property (@(posedge clock) disable iff (rst) $rose(mode_s));
  smb_write_c: cover property (@(posedge clock) disable iff (rst) swr);
  smb_read_c: cover property (@(posedge clock) disable iff (rst) req_new && !req.wr);
  port_write_c: cover property (@(posedge clock) disable iff (rst) mode_s && reg_we);
endmodule

// [psmux_pkg.sv]
package psmux_pkg;
  // ==========================================================
  // register map
  localparam int         REG_AW      = 4;
  localparam int         LANES       = 8;
  localparam int         SIDE_LANES  = 4;
  localparam logic [3:0] REG_CTRL    = 4'h8;
  localparam logic [3:0] REG_IDLE    = 4'h9;
  localparam logic [3:0] REG_STAT    = 4'ha;
  localparam logic [7:0] LANE_RST    = 8'h00;
  localparam logic [7:0] CTRL_RST    = 8'h01;
  localparam logic [7:0] IDLE_RST    = 8'h05;
  localparam int         CTRL_RATE   = 0;
  localparam int         CTRL_RXOVR  = 2;
  localparam int         CTRL_RXDET  = 3;
  localparam int         IDLE_OVR    = 4;
  // ==========================================================
  // smbus
  localparam logic [2:0] SMB_ADDR_HI = 3'h5; // arbitrary upper address bits
  localparam logic [3:0] BIT_ACK     = 4'h8;
  // ==========================================================
  // three-level pin codes
  localparam logic [1:0] TRI_LO      = 2'h0;
  localparam logic [1:0] TRI_MID     = 2'h1;
  localparam logic [1:0] TRI_HI      = 2'h2;

  typedef struct packed {
    logic hi;
    logic lo;
  } psmux_tri_t;

  typedef struct packed {
    logic [3:0] deemph;
    logic [3:0] eq;
  } psmux_lane_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
    logic [7:0] data;
  } psmux_req_t;

  typedef struct packed {
    psmux_tri_t [1:0] eqa;
    psmux_tri_t [1:0] eqb;
    psmux_tri_t [1:0] dema;
    psmux_tri_t [1:0] demb;
    psmux_tri_t [1:0] txidle;
    psmux_tri_t       rate;
    logic       [1:0] rxdet;
    logic             absent;
  } psmux_pins_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ADDR = 5'b00010,
    S_CMD  = 5'b00100,
    S_WDAT = 5'b01000,
    S_RDAT = 5'b10000
  } psmux_sst_t;

  // low, undriven middle, high
  function automatic logic [1:0] tri_dec(input psmux_tri_t p);
    if (p.hi)
      tri_dec = TRI_HI;
    else if (p.lo)
      tri_dec = TRI_LO;
    else
      tri_dec = TRI_MID;
  endfunction
endpackage

// [psmux_smb_slave.sv]
`timescale 1ns/1ps
module psmux_smb_slave (
  input  wire logic                    link_clk,
  input  wire logic                    link_rst,
  input  wire logic                    scl_pin,
  input  wire logic                    sda_pin,
  input  wire logic [3:0]              addr_pin,
  input  wire logic [7:0]              rsp_data,
  input  wire logic                    rsp_tgl,
  output logic                         sda_oe,
  output psmux_pkg::psmux_req_t        req_q,
  output logic                         req_tgl_q
);
  // ==========================================================
  // pin synchronisers and edges
  logic [1:0] scl_m, sda_m, rsp_m;
  logic [3:0] ad_m1, ad_q;
  logic       scl_p_q, sda_p_q, rsp_seen_q;
  logic [7:0] rd_q, sh_q;
  logic [3:0] cnt_q;
  logic       rise, fall, start, stop, match;
  psmux_pkg::psmux_sst_t st_q;

  always_ff @(posedge link_clk)
  begin
    scl_m   <= {scl_m[0], scl_pin};
    sda_m   <= {sda_m[0], sda_pin};
    rsp_m   <= {rsp_m[0], rsp_tgl};
    ad_m1   <= addr_pin;
    ad_q    <= ad_m1;
    scl_p_q <= scl_m[1];
    sda_p_q <= sda_m[1];
  end

  assign rise  = scl_m[1] & ~scl_p_q;
  assign fall  = ~scl_m[1] & scl_p_q;
  assign start = scl_m[1] & scl_p_q & sda_p_q & ~sda_m[1];
  assign stop  = scl_m[1] & scl_p_q & ~sda_p_q & sda_m[1];
  assign match = sh_q[7:1] == {psmux_pkg::SMB_ADDR_HI, ad_q};

  // ==========================================================
  // read data from the register side
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      rsp_seen_q <= 1'b0;
      rd_q       <= 8'h00;
    end
    else if (rsp_m[1] != rsp_seen_q)
    begin
      rsp_seen_q <= rsp_m[1];
      rd_q       <= rsp_data;
    end
  end

  // ==========================================================
  // byte engine
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      st_q   <= psmux_pkg::S_IDLE;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      sda_oe <= 1'b0;
    end
    else if (start)
    begin
      st_q   <= psmux_pkg::S_ADDR;
      cnt_q  <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (stop)
    begin
      st_q   <= psmux_pkg::S_IDLE;
      sda_oe <= 1'b0;
    end
    else if (rise)
    begin
      if (cnt_q != psmux_pkg::BIT_ACK)
      begin
        sh_q  <= {sh_q[6:0], sda_m[1]};
        cnt_q <= cnt_q + 4'h1;
      end
      else
      begin
        cnt_q <= 4'h0;
        if (st_q == psmux_pkg::S_RDAT && sda_m[1])
          st_q <= psmux_pkg::S_IDLE;
      end
    end
    else if (fall)
    begin
      if (cnt_q == psmux_pkg::BIT_ACK)
      begin
        unique case (st_q)
          psmux_pkg::S_ADDR:
          begin
            sda_oe <= match;
            if (!match)
              st_q <= psmux_pkg::S_IDLE;
            else if (sh_q[0])
              st_q <= psmux_pkg::S_RDAT;
            else
              st_q <= psmux_pkg::S_CMD;
          end
          psmux_pkg::S_CMD:
          begin
            sda_oe <= 1'b1;
            st_q   <= psmux_pkg::S_WDAT;
          end
          psmux_pkg::S_WDAT: sda_oe <= 1'b1;
          psmux_pkg::S_RDAT: sda_oe <= 1'b0;
          psmux_pkg::S_IDLE: sda_oe <= 1'b0;
        endcase
      end
      else
        sda_oe <= (st_q == psmux_pkg::S_RDAT) & ~rd_q[3'(3'd7 - cnt_q[2:0])];
    end
  end

  // ==========================================================
  // register requests toward the system clock
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      req_q     <= '0;
      req_tgl_q <= 1'b0;
    end
    else if (fall && cnt_q == psmux_pkg::BIT_ACK)
    begin
      if (st_q == psmux_pkg::S_CMD)
      begin
        req_q     <= '{wr: 1'b0, idx: sh_q, data: 8'h00};
        req_tgl_q <= ~req_tgl_q;
      end
      else if (st_q == psmux_pkg::S_WDAT)
      begin
        req_q     <= '{wr: 1'b1, idx: req_q.idx, data: sh_q};
        req_tgl_q <= ~req_tgl_q;
      end
    end
  end

  // ==========================================================
  // checks
  addr_nack_a: assert property (@(posedge link_clk) disable iff (link_rst)
    fall && !start && !stop && cnt_q == psmux_pkg::BIT_ACK
      && st_q == psmux_pkg::S_ADDR && !match |=> !sda_oe && st_q == psmux_pkg::S_IDLE)
    else $error("foreign address acknowledged");
  addr_ack_c: cover property (@(posedge link_clk) disable iff (link_rst)
    st_q == psmux_pkg::S_ADDR ##1 st_q == psmux_pkg::S_CMD);
endmodule

// [psmux_smb_host.sv]
`timescale 1ns/1ps
// ==========================================================
// smbus host model: drives the clock, only ever pulls data low
module psmux_smb_host (
  input  wire logic link_clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick;
    repeat (6) @(posedge link_clk);
  endtask

  // start or repeated start
  task automatic start;
    sda_low <= 1'b0;
    tick;
    scl <= 1'b1;
    tick;
    sda_low <= 1'b1;
    tick;
    scl <= 1'b0;
    tick;
  endtask

  task automatic stop;
    sda_low <= 1'b1;
    tick;
    scl <= 1'b1;
    tick;
    sda_low <= 1'b0;
    tick;
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    tick;
    scl <= 1'b1;
    tick;
    r = sda_in;
    tick;
    scl <= 1'b0;
    tick;
  endtask

  // byte msb first, then the ninth bit released
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(1'b1, a);
    ack = ~a;
  endtask

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] idx,
                           input logic [7:0] data, output logic ack);
    logic [7:0] rx;
    logic       a1, a2, a3;
    start;
    xfer({addr, 1'b0}, rx, a1);
    xfer(idx, rx, a2);
    xfer(data, rx, a3);
    stop;
    ack = a1 & a2 & a3;
  endtask

  // read ends with a not-acknowledge from the host
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] idx,
                          output logic [7:0] data, output logic ack);
    logic [7:0] rx;
    logic       a1, a2, a3, nak;
    start;
    xfer({addr, 1'b0}, rx, a1);
    xfer(idx, rx, a2);
    start;
    xfer({addr, 1'b1}, rx, a3);
    xfer(8'hff, data, nak);
    stop;
    ack = a1 & a2 & a3;
  endtask
endmodule

// [pin_smbus_mode_mux_test.sv]
`timescale 1ns/1ps
module pin_smbus_mode_mux_test;
  // ==========================================================
  // signals
  logic                                   clock, rst, link_clk, mode, absent;
  psmux_pkg::psmux_tri_t [1:0]            eqa, eqb, dema, demb, idle, dema_w;
  psmux_pkg::psmux_tri_t                  rate;
  logic [1:0]                             rxdet, rate_sel, rx_detect_sel;
  logic [3:0]                             reg_addr, tx_idle_sel;
  logic [7:0]                             reg_wdata, reg_rdata, d;
  logic                                   reg_we, reg_re, low_power, smb_mode;
  logic                                   sda_out, sda_oe, scl, sda_low, ack;
  psmux_pkg::psmux_lane_t [7:0]           lane_cfg;
  int                                     num_errors, comparisons, cycles;
  wire                                    sda = ~(sda_low | sda_oe);

  // board wiring: in smbus mode the side a de-emphasis pins carry the bus
  assign dema_w = mode ? {scl, 1'b0, sda, 1'b0} : dema;

  psmux_top psmux_top_i (
    .clock(clock), .rst(rst), .link_clk(link_clk), .serial_mgmt_mode_select(mode),
    .side_a_equalize_level_pins(eqa), .side_b_equalize_level_pins(eqb),
    .side_a_deemph_level_pins(dema_w), .side_b_deemph_level_pins(demb),
    .rate_pin(rate), .tx_idle_pins(idle), .rx_detect_pins(rxdet),
    .cable_absent_input(absent), .sda_out(sda_out), .sda_oe(sda_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .lane_cfg(lane_cfg), .rate_sel(rate_sel),
    .rx_detect_sel(rx_detect_sel), .tx_idle_sel(tx_idle_sel),
    .low_power(low_power), .smb_mode(smb_mode));

  psmux_smb_host psmux_smb_host_i (
    .link_clk(link_clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));

  // ==========================================================
  // clocks, timeout, helpers
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial
  begin
    link_clk = 1'b0;
    forever #16 link_clk = ~link_clk;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      report_and_stop;
    end
  end

  task automatic report_and_stop;
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic lanes_chk(input logic [7:0] a, input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      check(lane_cfg[i], (i < 4) ? a : b);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    lanes_chk(8'h00, 8'h00);
    check(rate_sel, 2'h1);
    check(tx_idle_sel, 4'h5);
    check({smb_mode, sda_oe, low_power}, 3'h0);
    check(sda_out, 1'b0);
  endtask

  task automatic t_pin_mode;
    wait_clk(6);
    lanes_chk(8'h29, 8'ha4);
    check(rate_sel, 2'h2);
    check(tx_idle_sel, 4'h6);
    check(rx_detect_sel, 2'h2);
    reg_wr(4'h0, 8'h77);
    rd_chk(4'h0, 8'h00);
    check(lane_cfg[0], 8'h29);
  endtask

  task automatic t_enter_smb;
    @(posedge clock);
    eqa  <= 4'h5;
    eqb  <= 4'h9;
    demb <= 4'h6;
    mode <= 1'b1;
    wait_clk(8);
    check(smb_mode, 1'b1);
    lanes_chk(8'h00, 8'h00);
    check(rate_sel, 2'h1);
    rd_chk(4'ha, 8'h19);
  endtask

  task automatic t_reg_port;
    reg_wr(4'h3, 8'h5a);
    reg_wr(4'h4, 8'ha5);
    reg_wr(4'ha, 8'hff);
    rd_chk(4'h3, 8'h5a);
    rd_chk(4'h4, 8'ha5);
    rd_chk(4'hb, 8'h00);
    rd_chk(4'ha, 8'h19);
    @(posedge clock);
    eqa <= 4'ha;
    wait_clk(6);
    check(lane_cfg[3], 8'h5a);
    check(lane_cfg[4], 8'ha5);
    check(lane_cfg[0], 8'h00);
  endtask

  task automatic t_smbus;
    psmux_smb_host_i.write_reg(7'h56, 8'h05, 8'h3c, ack);
    check(ack, 1'b1);
    wait_clk(10);
    check(lane_cfg[5], 8'h3c);
    psmux_smb_host_i.read_reg(7'h56, 8'h05, d, ack);
    check({ack, d}, 9'h13c);
    psmux_smb_host_i.write_reg(7'h57, 8'h06, 8'hff, ack);
    check(ack, 1'b0);
    wait_clk(10);
    check(lane_cfg[6], 8'h00);
  endtask

  task automatic t_absent;
    @(posedge clock);
    absent <= 1'b1;
    wait_clk(6);
    check(lane_cfg[5], 8'h3c);
    check(low_power, 1'b1);
    rd_chk(4'h3, 8'h5a);
    @(posedge clock);
    absent <= 1'b0;
  endtask

  task automatic t_override;
    @(posedge clock);
    rxdet <= 2'h3;
    wait_clk(6);
    check(rx_detect_sel, 2'h3);
    check(tx_idle_sel, 4'h6);
    check(low_power, 1'b0);
    reg_wr(4'h8, 8'h0c);
    reg_wr(4'h9, 8'h1a);
    @(posedge clock);
    rxdet <= 2'h0;
    wait_clk(6);
    check(rx_detect_sel, 2'h1);
    check(tx_idle_sel, 4'ha);
    check(rate_sel, 2'h0);
  endtask

  task automatic t_leave_smb;
    @(posedge clock);
    mode <= 1'b0;
    eqa  <= 4'h8;
    eqb  <= 4'h1;
    demb <= 4'ha;
    wait_clk(10);
    lanes_chk(8'h29, 8'ha4);
    rd_chk(4'h3, 8'h00);
    rd_chk(4'h8, 8'h01);
    check(rx_detect_sel, 2'h0);
    check(tx_idle_sel, 4'h6);
    check(rate_sel, 2'h2);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    num_errors  = 0;
    comparisons = 0;
    cycles      = 0;
    rst         = 1'b1;
    mode        = 1'b0;
    absent      = 1'b0;
    eqa         = 4'h8;
    eqb         = 4'h1;
    dema        = 4'h6;
    demb        = 4'ha;
    idle        = 4'h2;
    rate        = 2'h2;
    rxdet       = 2'h2;
    reg_addr    = 4'h0;
    reg_wdata   = 8'h00;
    reg_we      = 1'b0;
    reg_re      = 1'b0;
    wait_clk(8);
    t_reset;
    @(posedge clock);
    rst <= 1'b0;
    t_pin_mode;
    t_enter_smb;
    t_reg_port;
    t_smbus;
    t_absent;
    t_override;
    t_leave_smb;
    report_and_stop;
  end
endmodule
